/* File: rtl/scs_stage_chain.sv */
// Stage chain supervisor: sequences stages, watches them, gates calibration.
// Assumes stages and the calibration source run on clk; panel pins do not.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"

module scs_stage_chain #(
   parameter int unsigned NUM_STAGES = 4,
   parameter int unsigned DATA_W     = 16,
   parameter int unsigned SAFE_FIRST = 1,
   parameter int unsigned STAGE_CYC  = `SCS_STAGE_TO_CYC,
   parameter int unsigned WD_TIMEOUT = `SCS_WD_TO_CYC,
   parameter logic [1:0]  DIVISION   = 2'h0
) (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   // Register port
   input  wire logic [3:0]                   regAddr,
   input  wire logic [15:0]                  regWdata,
   input  wire logic                         regWr,
   input  wire logic                         regRd,
   output logic      [15:0]                  regRdata,
   // Stage chain
   output logic      [NUM_STAGES-1:0]        stageStart,
   output logic      [DATA_W-1:0]            stageDin,
   input  wire logic [NUM_STAGES-1:0]        stageDone,
   input  wire logic [NUM_STAGES*DATA_W-1:0] stageDout,
   // Panel and power pins
   input  wire logic                         powerGood,
   input  wire logic                         manualInop,
   input  wire logic                         operatorAccept,
   // Calibration input from the nonsafety side
   input  wire logic                         calValid,
   input  wire logic [15:0]                  calWord,
   output logic      [`SCS_CAL_GAIN_W-1:0]   calGain,
   output logic                              calLoad,
   // Outbound one-way link
   output logic                              txValid,
   output logic      [DATA_W+1:0]            txData,
   // Status
   output logic                              inoperable,
   output logic                              tripOut,
   output logic                              alert,
   output logic                              irq
);
   import scs_pkg::*;

   localparam int IW = $clog2(NUM_STAGES);

   typedef struct packed {
      scs_chain_e                 fsm;
      logic [IW-1:0]              idx;
      logic [15:0]                timer;
      logic [NUM_STAGES-1:0]      start;
      logic [DATA_W-1:0]          din;
      logic                       kick;
      logic                       txValid;
      logic [DATA_W+1:0]          txData;
      logic [2:0]                 sync1;
      logic [2:0]                 sync2;
      logic                       accPrev;
      logic                       run;
      logic                       stallFlt;
      logic                       stallSafe;
      logic [IW-1:0]              stallIdx;
      logic                       pwrFlt;
      logic                       wdFlt;
      logic                       inop;
      logic                       trip;
      logic                       alert;
      logic [`SCS_EV_NUM-1:0]     status;
      logic [`SCS_EV_NUM-1:0]     mask;
      logic                       irq;
      logic                       calPend;
      logic [`SCS_CAL_GAIN_W-1:0] calBuf;
      logic [`SCS_CAL_GAIN_W-1:0] gain;
      logic                       calLoad;
      logic [7:0]                 discards;
      logic [15:0]                rdata;
   } scs_state_s;

   scs_state_s s;
   scs_state_s n;
   logic [1:0] wdExp;

   // Two watchdogs, both kicked by a completed chain
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gWatch
         scs_watchdog #(
            .TIMEOUT (WD_TIMEOUT)
         ) uWatch (
            .clk     (clk),
            .reset_n (reset_n),
            .enable  (s.run),
            .kick    (s.kick),
            .expired (wdExp[g])
         );
      end
   endgenerate

   // Next-state logic
   always_comb begin
      logic [`SCS_EV_NUM-1:0] ev;
      logic [DATA_W-1:0]      dout;
      logic                   clr;
      logic                   pwrLoss;
      logic                   stallSet;
      logic                   fmtOk;
      logic                   acceptEdge;
      logic                   inopMan;
      n          = s;
      ev         = '0;
      dout       = stageDout[s.idx*DATA_W +: DATA_W];
      clr        = regWr && (regAddr == `SCS_ADDR_CTRL)
                   && regWdata[`SCS_CTRL_CLR];
      pwrLoss    = ~s.sync2[0];
      stallSet   = 1'b0;
      inopMan    = s.sync2[1];
      acceptEdge = s.sync2[2] & ~s.accPrev;
      fmtOk      = (calWord[15:12] == `SCS_CAL_HDR)
                   && (calWord[11:10] == DIVISION) && ~^calWord;

      // Pin synchronisers: power, manual inop, accept
      n.sync1   = {operatorAccept, manualInop, powerGood};
      n.sync2   = s.sync1;
      n.accPrev = s.sync2[2];

      // Software control
      if (regWr && regAddr == `SCS_ADDR_CTRL) begin
         n.run = regWdata[`SCS_CTRL_RUN];
      end
      if (regWr && regAddr == `SCS_ADDR_MASK) begin
         n.mask = regWdata[`SCS_EV_NUM-1:0];
      end

      // Chain sequencer
      n.start   = '0;
      n.kick    = 1'b0;
      n.txValid = 1'b0;
      case (s.fsm)
         SCS_IDLE: begin
            n.timer = '0;
            if (s.run && !s.stallFlt && !s.pwrFlt && !s.wdFlt) begin
               n.fsm   = SCS_WAIT;
               n.idx   = '0;
               n.start = NUM_STAGES'(1);
               n.din   = '0;
            end
         end
         SCS_WAIT: begin
            if (pwrLoss) begin
               n.fsm = SCS_HALT;
            end else if (stageDone[s.idx]) begin
               n.timer = '0;
               if (s.idx == IW'(NUM_STAGES - 1)) begin
                  n.kick   = 1'b1;
                  n.txValid = 1'b1;
                  n.txData = {DIVISION, dout};
                  ev[`SCS_EV_DONE] = 1'b1;
                  n.fsm    = SCS_IDLE;
               end else begin
                  n.idx   = s.idx + IW'(1);
                  n.start = NUM_STAGES'(1) << (s.idx + IW'(1));
                  n.din   = dout;
               end
            end else if (s.timer == 16'(STAGE_CYC - 1)) begin
               stallSet   = 1'b1;
               n.stallIdx = s.idx;
               n.fsm      = SCS_HALT;
            end else begin
               n.timer = s.timer + 16'h0001;
            end
         end
         SCS_HALT: begin
            if (clr) begin
               n.fsm = SCS_IDLE;
            end
         end
         default: begin
            n.fsm = SCS_IDLE;
         end
      endcase

      // Fault latches, set wins over clear
      n.stallFlt  = (s.stallFlt & ~clr) | stallSet;
      n.stallSafe = (s.stallSafe & ~clr)
                    | (stallSet && (32'(s.idx) >= SAFE_FIRST));
      n.pwrFlt    = (s.pwrFlt & ~clr) | pwrLoss;
      n.wdFlt     = (s.wdFlt & ~clr) | (|wdExp);
      ev[`SCS_EV_STALL] = stallSet;
      ev[`SCS_EV_WDOG]  = (|wdExp) & ~s.wdFlt;
      ev[`SCS_EV_PWR]   = pwrLoss & ~s.pwrFlt;

      // Calibration gate
      n.calLoad = 1'b0;
      if (!inopMan) begin
         n.calPend = 1'b0;
      end
      if (calValid) begin
         if (fmtOk && inopMan) begin
            n.calPend = 1'b1;
            n.calBuf  = calWord[`SCS_CAL_GAIN_W:1];
         end else begin
            n.discards = s.discards + 8'h01;
            ev[`SCS_EV_CALBAD] = 1'b1;
         end
      end
      if (s.calPend && inopMan && acceptEdge) begin
         n.gain    = s.calBuf;
         n.calLoad = 1'b1;
         n.calPend = 1'b0;
         ev[`SCS_EV_CALOK] = 1'b1;
      end

      // Status outputs
      n.inop  = n.stallSafe | n.pwrFlt | n.wdFlt | inopMan;
      n.trip  = n.inop;
      n.alert = n.stallFlt | n.pwrFlt | n.wdFlt;

      // Sticky events, cleared by reading status
      if (regRd && regAddr == `SCS_ADDR_STATUS) begin
         n.status = ev;
      end else begin
         n.status = s.status | ev;
      end
      n.irq = |(n.status & n.mask);

      // Read data, valid the cycle after the strobe
      n.rdata = '0;
      if (regRd) begin
         case (regAddr)
            `SCS_ADDR_CTRL:    n.rdata = 16'({1'b0, s.run});
            `SCS_ADDR_STATUS:  n.rdata = 16'(s.status);
            `SCS_ADDR_MASK:    n.rdata = 16'(s.mask);
            `SCS_ADDR_STATE:   n.rdata = 16'({s.fsm, s.stallIdx, s.inop,
                                  s.wdFlt, s.pwrFlt, s.stallFlt});
            `SCS_ADDR_DISCARD: n.rdata = 16'(s.discards);
            `SCS_ADDR_CALGAIN: n.rdata = 16'(s.gain);
            default:           n.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s       <= '0;
         s.fsm   <= SCS_IDLE;
         s.sync1 <= `SCS_SYNC_RST;
         s.sync2 <= `SCS_SYNC_RST;
         s.mask  <= `SCS_MASK_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from flops
   assign regRdata   = s.rdata;
   assign stageStart = s.start;
   assign stageDin   = s.din;
   assign txValid    = s.txValid;
   assign txData     = s.txData;
   assign calGain    = s.gain;
   assign calLoad    = s.calLoad;
   assign inoperable = s.inop;
   assign tripOut    = s.trip;
   assign alert      = s.alert;
   assign irq        = s.irq;

   // Checks
   a_start_after_done: assert property (
      @(posedge clk) disable iff (!reset_n)
      (|stageStart && !stageStart[0]) |-> $past(|stageDone))
      else $error("stage started without a handoff");

   a_kick_on_last: assert property (
      @(posedge clk) disable iff (!reset_n)
      s.kick |-> $past(stageDone[NUM_STAGES-1]) && $past(s.fsm) == SCS_WAIT)
      else $error("watchdog kicked before chain end");

   a_halt_no_start: assert property (
      @(posedge clk) disable iff (!reset_n)
      (s.fsm == SCS_HALT) |-> (stageStart == '0) ##1 (stageStart == '0))
      else $error("stage started after a stall");

   a_safe_stall_inop: assert property (
      @(posedge clk) disable iff (!reset_n)
      ($rose(s.stallFlt) && 32'(s.stallIdx) >= SAFE_FIRST)
      |-> inoperable && tripOut)
      else $error("safety stall did not mark inoperable");

   a_power_trip: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!powerGood [*3]) |-> ##[0:1] (inoperable && tripOut))
      else $error("power loss without trip");

   a_fault_alert: assert property (
      @(posedge clk) disable iff (!reset_n)
      (s.stallFlt || s.pwrFlt || s.wdFlt) |-> alert)
      else $error("fault without operator alert");

   a_alert_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      $fell(alert) |-> $past(regWr && regAddr == `SCS_ADDR_CTRL
                             && regWdata[`SCS_CTRL_CLR]))
      else $error("operator alert dropped without a clear");

   a_tx_division: assert property (
      @(posedge clk) disable iff (!reset_n)
      txValid |-> (txData[DATA_W+1:DATA_W] == DIVISION) && $past(s.fsm)
      == SCS_WAIT)
      else $error("frame carries foreign division");

   a_cal_gate: assert property (
      @(posedge clk) disable iff (!reset_n)
      calLoad |-> $past(s.sync2[1]) && $past(s.calPend))
      else $error("calibration loaded without manual inop");

   a_bad_discard: assert property (
      @(posedge clk) disable iff (!reset_n)
      (calValid && (calWord[15:12] != `SCS_CAL_HDR))
      |=> s.discards == 8'($past(s.discards) + 8'h01) && !calLoad)
      else $error("malformed calibration word not discarded");

   a_wd_inop: assert property (
      @(posedge clk) disable iff (!reset_n)
      (|wdExp) |=> inoperable ##1 inoperable)
      else $error("watchdog timeout without inoperable");

   c_chain_done: cover property (
      @(posedge clk) disable iff (!reset_n) s.kick);
   c_stall: cover property (
      @(posedge clk) disable iff (!reset_n) $rose(s.stallFlt));
   c_cal_load: cover property (
      @(posedge clk) disable iff (!reset_n) calLoad);
   c_irq: cover property (
      @(posedge clk) disable iff (!reset_n) $rose(irq));

endmodule : scs_stage_chain
`default_nettype wire

/* File: common/scs_defines.svh */
// Constants of the stage chain supervisor: offsets, fields, resets, times.
// Assumes inclusion by bare name from common/.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// Clock rate and times
`define SCS_CLK_MHZ       20
`define SCS_STAGE_TO_US   10
`define SCS_STAGE_TO_CYC  (`SCS_STAGE_TO_US * `SCS_CLK_MHZ)
`define SCS_WD_TO_US      500
`define SCS_WD_TO_CYC     (`SCS_WD_TO_US * `SCS_CLK_MHZ)

// Register offsets
`define SCS_ADDR_CTRL     4'h0
`define SCS_ADDR_STATUS   4'h1
`define SCS_ADDR_MASK     4'h2
`define SCS_ADDR_STATE    4'h3
`define SCS_ADDR_DISCARD  4'h4
`define SCS_ADDR_CALGAIN  4'h5

// Control fields
`define SCS_CTRL_RUN      0
`define SCS_CTRL_CLR      1

// Status and mask fields
`define SCS_EV_DONE       0
`define SCS_EV_STALL      1
`define SCS_EV_WDOG       2
`define SCS_EV_PWR        3
`define SCS_EV_CALOK      4
`define SCS_EV_CALBAD     5
`define SCS_EV_NUM        6

// Reset values
`define SCS_MASK_RST      6'h00
`define SCS_SYNC_RST      3'h1

// Calibration word: header, division, gain, even parity
`define SCS_CAL_HDR       4'hA
`define SCS_CAL_GAIN_W    9

`endif

/* File: common/scs_pkg.sv */
// Types shared by the stage chain supervisor.
// Assumes no other package.
package scs_pkg;

   // Chain sequencer states
   typedef enum logic [1:0] {
      SCS_IDLE,
      SCS_WAIT,
      SCS_HALT
   } scs_chain_e;

endpackage : scs_pkg

/* File: rtl/scs_watchdog.sv */
// Retriggerable watchdog timer: expires when not kicked in time.
// Assumes kick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"

module scs_watchdog #(
   parameter int unsigned TIMEOUT = `SCS_WD_TO_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control
   input  wire logic enable,
   input  wire logic kick,
   // Result
   output logic      expired
);
   import scs_pkg::*;

   typedef struct packed {
      logic [23:0] count;
      logic        expired;
   } scs_wd_s;

   scs_wd_s wdReg;
   scs_wd_s wdNext;

   // Count up while enabled, restart on kick
   always_comb begin
      wdNext = wdReg;
      if (kick || !enable) begin
         wdNext.count   = '0;
         wdNext.expired = 1'b0;
      end else if (wdReg.count == 24'(TIMEOUT - 1)) begin
         wdNext.expired = 1'b1;
      end else begin
         wdNext.count = wdReg.count + 24'h000001;
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdReg <= '0;
      end else begin
         wdReg <= wdNext;
      end
   end

   assign expired = wdReg.expired;

endmodule : scs_watchdog
`default_nettype wire

/* File: verif/scs_stage_model.sv */
// Model of the stage boards that sit behind the chain supervisor.
// Assumes one-hot start pulses on clk; answers LAT cycles after start.
`timescale 1ns/1ps
`default_nettype none

module scs_stage_model #(
   parameter int N   = 4,
   parameter int LAT = 3
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            reset_n,
   // Stage side
   input  wire logic [N-1:0]    stageStart,
   input  wire logic [15:0]     stageDin,
   output logic      [N-1:0]    stageDone,
   output logic      [N*16-1:0] stageDout,
   // Test control
   input  wire logic            stallEn,
   input  wire logic [1:0]      stallIdx,
   output int                   hoErr
);
   logic [15:0] res;
   logic [15:0] hold;
   logic [15:0] given;
   logic        busy;
   int          cnt;
   int          cur;
   int          nxt;
   int          k;

   // Every slice shows the one result; it is inverted outside done
   assign stageDout = {N{res}};

   // One stage at a time, data only, no control back
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stageDone <= '0;
         res       <= '0;
         busy      <= 1'b0;
         hoErr     <= 0;
         nxt       <= 0;
      end else begin
         stageDone <= '0;
         res       <= ~res;
         k = 0;
         for (int i = 0; i < N; i++) if (stageStart[i]) k = i;
         if (stageStart != '0) begin
            // Later stage must follow its predecessor with its data
            if (!$onehot(stageStart) ||
                (k != 0 && (k != nxt || stageDin !== given))) begin
               hoErr <= hoErr + 1;
            end
            cur  <= k;
            hold <= stageDin;
            cnt  <= LAT;
            busy <= !(stallEn && k == int'(stallIdx));
         end else if (busy) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               stageDone[cur] <= 1'b1;
               res            <= {4'(cur + 1), hold[11:0]};
               given          <= {4'(cur + 1), hold[11:0]};
               nxt            <= (cur + 1) % N;
               busy           <= 1'b0;
            end
         end
      end
   end
endmodule : scs_stage_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the stage chain supervisor.
// Assumes the stage model answers within a few cycles.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"

module tb;
   localparam logic [1:0] DIV = 2'h2;
   logic        clk, reset_n, regWr, regRd, powerGood, manualInop;
   logic        operatorAccept, calValid, calLoad, txValid, stallEn;
   logic        inoperable, tripOut, alert, irq;
   logic [3:0]  regAddr, stageStart, stageDone;
   logic [15:0] regWdata, regRdata, calWord, stageDin, d;
   logic [8:0]  calGain;
   logic [17:0] txData;
   logic [63:0] stageDout;
   logic [1:0]  stallIdx;
   int          hoErr, errTotal, numChecks, cyc;

   scs_stage_chain #(.STAGE_CYC(20), .WD_TIMEOUT(100), .DIVISION(DIV)) u_dut (
      .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .stageStart(stageStart), .stageDin(stageDin), .stageDone(stageDone),
      .stageDout(stageDout), .powerGood(powerGood), .manualInop(manualInop),
      .operatorAccept(operatorAccept), .calValid(calValid),
      .calWord(calWord), .calGain(calGain), .calLoad(calLoad),
      .txValid(txValid), .txData(txData), .inoperable(inoperable),
      .tripOut(tripOut), .alert(alert), .irq(irq));

   scs_stage_model u_stage (
      .clk(clk), .reset_n(reset_n), .stageStart(stageStart),
      .stageDin(stageDin), .stageDone(stageDone), .stageDout(stageDout),
      .stallEn(stallEn), .stallIdx(stallIdx), .hoErr(hoErr));

   // Clock of 50 ns
   always #25 clk = ~clk;

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errTotal++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [17:0] seen, input logic [17:0] exp,
                        input string what);
      numChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wait_hi(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'b1; i++) tick(1);
   endtask : wait_hi

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= v;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   // Read data stand in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask : rd

   task automatic send_cal(input logic [15:0] w);
      @(posedge clk);
      calValid <= 1'b1;
      calWord  <= w;
      @(posedge clk);
      calValid <= 1'b0;
   endtask : send_cal

   // Header, division, gain, even parity; bad flips the parity
   function automatic logic [15:0] cw(input logic [3:0] h,
      input logic [1:0] v, input logic [8:0] g, input logic bad);
      return {h, v, g, ^{h, v, g} ^ bad};
   endfunction : cw

   task automatic t_chain;
      wr(`SCS_ADDR_CTRL, 16'h0001);
      wait_hi(txValid, 80);
      check(txValid, 1'b1, "frame");
      check(txData[17:12], {DIV, 4'h4}, "frame data");
      check(txData[17:16], DIV, "division");
      tick(300);
      check(inoperable, 1'b0, "kicked");
      check(18'(hoErr), 18'h0, "order");
      wr(`SCS_ADDR_CTRL, 16'h0000);
      tick(30);
      rd(`SCS_ADDR_STATUS, d);
      check(d[`SCS_EV_DONE], 1'b1, "done ev");
      rd(4'hF, d);
      check(d, 16'h0000, "unmapped");
      $display("test chain over");
   endtask : t_chain

   task automatic t_irq;
      wr(`SCS_ADDR_MASK, 16'h0001);
      rd(`SCS_ADDR_STATUS, d);
      wr(`SCS_ADDR_CTRL, 16'h0001);
      wait_hi(txValid, 80);
      tick(2);
      check(irq, 1'b1, "irq up");
      wr(`SCS_ADDR_CTRL, 16'h0000);
      tick(30);
      rd(`SCS_ADDR_STATUS, d);
      tick(1);
      check(irq, 1'b0, "irq clear");
      wr(`SCS_ADDR_MASK, 16'h0000);
      $display("test irq over");
   endtask : t_irq

   task automatic t_stall(input logic [1:0] idx);
      @(posedge clk);
      stallIdx <= idx;
      stallEn  <= 1'b1;
      rd(`SCS_ADDR_STATUS, d);
      wr(`SCS_ADDR_CTRL, 16'h0001);
      wait_hi(alert, 200);
      check(alert, 1'b1, "stall alert");
      check(inoperable, idx != 2'h0, "stall inop");
      rd(`SCS_ADDR_STATUS, d);
      check(d[`SCS_EV_STALL], 1'b1, "stall ev");
      tick(120);
      check(inoperable, 1'b1, "wdog inop");
      rd(`SCS_ADDR_STATUS, d);
      check(d[`SCS_EV_WDOG], 1'b1, "wdog ev");
      rd(`SCS_ADDR_STATE, d);
      check(d, {8'h00, 2'h2, idx, 4'hD}, "halt state");
      check(18'(hoErr), 18'h0, "no later start");
      @(posedge clk);
      stallEn <= 1'b0;
      wr(`SCS_ADDR_CTRL, 16'h0000);
      // Let the stopped watchdogs drop their expiry before the clear
      tick(1);
      wr(`SCS_ADDR_CTRL, 16'h0002);
      tick(2);
      check(alert, 1'b0, "cleared");
      $display("test stall %0d over", idx);
   endtask : t_stall

   task automatic t_power;
      @(posedge clk);
      powerGood <= 1'b0;
      tick(6);
      check(inoperable, 1'b1, "pwr inop");
      check(tripOut, 1'b1, "pwr trip");
      rd(`SCS_ADDR_STATUS, d);
      check(d[`SCS_EV_PWR], 1'b1, "pwr ev");
      @(posedge clk);
      powerGood <= 1'b1;
      tick(4);
      wr(`SCS_ADDR_CTRL, 16'h0002);
      tick(2);
      check(tripOut, 1'b0, "trip gone");
      $display("test power over");
   endtask : t_power

   task automatic t_cal;
      logic [15:0] w [4];
      logic [7:0]  n;
      w = '{cw(4'hA, DIV, 9'h1A5, 1'b0), cw(4'hA, DIV, 9'h1A5, 1'b1),
            cw(4'h5, DIV, 9'h1A5, 1'b0), cw(4'hA, 2'h1, 9'h1A5, 1'b0)};
      rd(`SCS_ADDR_DISCARD, d);
      n = d[7:0];
      for (int i = 0; i < 4; i++) begin
         send_cal(w[i]);
         rd(`SCS_ADDR_DISCARD, d);
         check(d[7:0], 8'(n + i + 1), "discard");
      end
      rd(`SCS_ADDR_STATUS, d);
      check(d[`SCS_EV_CALBAD], 1'b1, "bad ev");
      @(posedge clk);
      manualInop <= 1'b1;
      tick(5);
      check(inoperable, 1'b1, "manual");
      send_cal(w[0]);
      rd(`SCS_ADDR_DISCARD, d);
      check(d[7:0], 8'(n + 4), "kept");
      @(posedge clk);
      operatorAccept <= 1'b1;
      wait_hi(calLoad, 12);
      check(calLoad, 1'b1, "load");
      check(calGain, 9'h1A5, "gain");
      rd(`SCS_ADDR_CALGAIN, d);
      check(d, 16'h01A5, "gain reg");
      rd(`SCS_ADDR_STATUS, d);
      check(d[`SCS_EV_CALOK], 1'b1, "cal ok ev");
      @(posedge clk);
      operatorAccept <= 1'b0;
      manualInop     <= 1'b0;
      tick(5);
      wr(`SCS_ADDR_CTRL, 16'h0002);
      tick(2);
      check(inoperable, 1'b0, "back");
      $display("test cal over");
   endtask : t_cal

   // Reset for two cycles, then the scenarios
   initial begin
      {clk, reset_n, regWr, regRd, calValid, stallEn} = '0;
      {manualInop, operatorAccept, regAddr, regWdata, calWord} = '0;
      {stallIdx, errTotal, numChecks, cyc} = '0;
      powerGood = 1'b1;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      tick(1);
      check(stageStart, 4'h0, "idle");
      t_chain();
      t_irq();
      t_stall(2'h0);
      t_stall(2'h2);
      t_power();
      t_cal();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
